// ==== hw/smh_pkg.sv ====
// Package of constants and types for the modem handshake sequencer
package smh_pkg;
   // Clock and timing
   localparam int unsigned CLK_HZ          = 125_000_000;
   localparam int unsigned TICK_NS         = 1_000_000;
   localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
   localparam int unsigned UNIT_MS         = 20;
   localparam int unsigned CTS_WAIT_MS     = 1000;
   localparam int unsigned BAUD_DIV_DEF    = 1085;
   // Register offsets
   localparam logic [3:0]  REG_CTRL        = 4'h0;
   localparam logic [3:0]  REG_DELAY       = 4'h1;
   localparam logic [3:0]  REG_STATUS     = 4'h2;
   localparam logic [3:0]  REG_MASK        = 4'h3;
   localparam logic [3:0]  REG_TXDATA      = 4'h4;
   localparam logic [3:0]  REG_RXDATA      = 4'h5;
   localparam logic [3:0]  REG_BAUD        = 4'h6;
   localparam logic [3:0]  REG_SEND        = 4'h7;
   // Field positions
   localparam int unsigned CTRL_MODE_LSB   = 0;
   localparam int unsigned CTRL_PAR_BIT    = 3;
   localparam int unsigned CTRL_CHK_BIT    = 4;
   localparam int unsigned CTRL_ADDR_LSB   = 8;
   localparam int unsigned CTRL_CCW_LSB    = 16;
   localparam logic [7:0]  BCAST_ADDR      = 8'hff;
   // Status bits
   localparam int unsigned ST_SENT         = 0;
   localparam int unsigned ST_ABORT_CTS    = 1;
   localparam int unsigned ST_ABORT_DCD    = 2;
   localparam int unsigned ST_RX           = 3;
   localparam int unsigned ST_PERR         = 4;
   localparam int unsigned ST_BADADDR      = 5;
   localparam int unsigned ST_W            = 6;
   // Reset values
   localparam logic [31:0] CTRL_RST        = 32'h0000_0000;
   localparam logic [31:0] DELAY_RST       = 32'h0000_0000;
   localparam logic [15:0] BAUD_RST        = 16'h043d;

   // Control-line modes
   typedef enum logic [2:0] {
      SMH_NOHS, SMH_FULL, SMH_HALF, SMH_RADIO, SMH_CARRIER
   } smh_mode_t;

   typedef enum logic [2:0] {
      SMH_IDLE, SMH_PRE, SMH_LEAD, SMH_WCTS, SMH_WDCD, SMH_SEND, SMH_TRAIL
   } smh_state_t;
endpackage : smh_pkg

// ==== hw/smh_top.sv ====
// Modem control-line sequencer with a small serial transmitter and receiver
// Function
// R1 - No handshake: RTS off, CTS ignored
// R2 - Full-duplex mode: RTS always high
// R3 - Half-duplex: RTS only around transmission
// R4 - Characters start only while CTS active
// R5 - Radio mode: wait one second, then discard
// R6 - Carrier mode: receive only while DCD active
// R7 - Carrier mode: send needs DCD clear, timeout
// R8 - Lead delay in 20 ms before CTS check
// R9 - After lead, CTS within one second else abort; here the second counts from RTS rise, lead included
// R10 - Zero lead: send on CTS, one-second abort
// R11 - Trail delay in 20 ms after last char
// R12 - Lead and trail used only in half-duplex
// R13 - Even parity or none
// R14 - Address 0 to 254; 255 rejected
// R15 - BCC or CRC selectable check
// R16 - One common bit rate
// R17 - Three master control-line modes offered
// R18 - Pre-keying delay in 1 ms before RTS
// R19 - All timing from a 1 ms tick; here the bit timing comes from the baud divider instead
//
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ns
module smh_top (
   input  wire logic        i_ref_clk,
   input  wire logic        i_rst,
   input  wire logic [3:0]  i_addr,
   input  wire logic [31:0] i_wdata,
   input  wire logic        i_wr,
   input  wire logic        i_rd,
   output logic      [31:0] o_rdata,
   input  wire logic        i_cts,
   input  wire logic        i_dcd,
   input  wire logic        i_rxd,
   output logic             o_rts,
   output logic             o_txd,
   output logic             o_irq
);
   localparam int unsigned ST_W = smh_pkg::ST_W;

   typedef struct packed {
      logic [31:0]       ctrl;      // mode, parity, check, address, carrier wait
      logic [31:0]       delay;     // pre[15:0] lead[23:16] trail[31:24]
      logic [15:0]       baud;
      logic [ST_W-1:0]   status;
      logic [ST_W-1:0]   mask;
      logic [7:0]        txbyte;
      logic [7:0]        rxbyte;
      logic              pend;      // packet ready to send
      logic              last;      // this byte ends the packet
      logic              txfull;
      smh_pkg::smh_state_t st;
      logic [16:0]       pre_cnt;   // 1 ms prescaler
      logic [15:0]       tmr;       // ms counter of the active wait
      logic [9:0]        cts_ms;    // ms since RTS rose
      logic              rts;
      logic [15:0]       tx_div;
      logic [3:0]        tx_bit;
      logic [10:0]       tx_sh;
      logic              txd;
      logic [15:0]       rx_div;
      logic [3:0]        rx_bit;
      logic [9:0]        rx_sh;
      logic              rx_busy;
      logic [1:0]        cts_s, dcd_s, rxd_s;  // synchroniser chains
      logic [15:0]       chk;       // running BCC or CRC of the packet
      logic [31:0]       rdata;
   } smh_st_t;

   smh_st_t r, n;
   logic       tick, cts, dcd, half, send_ok, go;
   logic [7:0] lead_ms_u, trail_u;
   smh_pkg::smh_mode_t mode;

   // Even parity of a byte
   function automatic logic even_par(input logic [7:0] d);
      even_par = ^d;
   endfunction : even_par

   // CRC-16 step over one byte, reflected 0xA001
   function automatic logic [15:0] crc_step(input logic [15:0] c, input logic [7:0] d);
      logic [15:0] x;
      x = c ^ {8'h00, d};
      for (int i = 0; i < 8; i++) begin
         x = x[0] ? ((x >> 1) ^ 16'ha001) : (x >> 1);
      end
      crc_step = x;
   endfunction : crc_step

   // Twenty-millisecond units to ms count
   function automatic logic [15:0] units_ms(input logic [7:0] u);
      units_ms = 16'({u, 4'h0}) + 16'({u, 2'h0});
   endfunction : units_ms

   // Decoded views of the state
   always_comb begin
      mode      = smh_pkg::smh_mode_t'(r.ctrl[smh_pkg::CTRL_MODE_LSB +: 3]);
      cts       = r.cts_s[1];
      dcd       = r.dcd_s[1];
      tick      = (r.pre_cnt == 17'(smh_pkg::CYC_PER_MS - 1));   // [R19]
      half      = (mode == smh_pkg::SMH_HALF) || (mode == smh_pkg::SMH_RADIO) ||
                  (mode == smh_pkg::SMH_CARRIER);
      lead_ms_u = half ? r.delay[23:16] : 8'h00;                 // [R12]
      trail_u   = half ? r.delay[31:24] : 8'h00;                 // [R12]
      // CTS gates characters in every handshaking mode
      send_ok   = (mode == smh_pkg::SMH_NOHS) || cts;            // [R1] [R4]
      go        = send_ok && (mode != smh_pkg::SMH_CARRIER || !dcd);  // [R7]
   end

   // Next-state logic
   always_comb begin
      n = r;
      n.cts_s = {r.cts_s[0], i_cts};
      n.dcd_s = {r.dcd_s[0], i_dcd};
      n.rxd_s = {r.rxd_s[0], i_rxd};
      n.pre_cnt = tick ? 17'h0_0000 : r.pre_cnt + 17'h0_0001;
      n.rdata = 32'h0000_0000;

      // Register writes
      if (i_wr) begin
         case (i_addr)
            smh_pkg::REG_CTRL: begin
               n.ctrl = i_wdata;
               if (i_wdata[smh_pkg::CTRL_ADDR_LSB +: 8] == smh_pkg::BCAST_ADDR) begin
                  n.ctrl[smh_pkg::CTRL_ADDR_LSB +: 8] = r.ctrl[smh_pkg::CTRL_ADDR_LSB +: 8];
                  n.status[smh_pkg::ST_BADADDR] = 1'b1;           // [R14]
               end
               if (i_wdata[2:0] > 3'(smh_pkg::SMH_CARRIER)) begin
                  n.ctrl[2:0] = r.ctrl[2:0];
               end
            end
            smh_pkg::REG_DELAY:  n.delay = i_wdata;
            smh_pkg::REG_MASK:   n.mask  = i_wdata[ST_W-1:0];
            smh_pkg::REG_BAUD:   n.baud  = i_wdata[15:0];          // [R16]
            smh_pkg::REG_TXDATA: begin
               n.txbyte = i_wdata[7:0];
               n.last   = i_wdata[8];
               n.txfull = 1'b1;
            end
            smh_pkg::REG_SEND: begin
               n.pend = 1'b1;
               n.chk  = 16'h0000;
            end
            default: ;
         endcase
      end

      // Register reads, status cleared on read
      if (i_rd) begin
         case (i_addr)
            smh_pkg::REG_CTRL:   n.rdata = r.ctrl;
            smh_pkg::REG_DELAY:  n.rdata = r.delay;
            smh_pkg::REG_STATUS: begin
               n.rdata  = {{(32-ST_W){1'b0}}, r.status};
               n.status = '0;
            end
            smh_pkg::REG_MASK:   n.rdata = {{(32-ST_W){1'b0}}, r.mask};
            smh_pkg::REG_RXDATA: n.rdata = {r.chk, 7'h00, r.txfull, r.rxbyte};
            smh_pkg::REG_BAUD:   n.rdata = {16'h0000, r.baud};
            smh_pkg::REG_SEND:   n.rdata = {24'h00_0000, 6'(r.st), r.rts, r.pend};
            default:             n.rdata = 32'h0000_0000;
         endcase
      end

      if (tick && r.tmr != 16'h0000) n.tmr = r.tmr - 16'h0001;
      if (tick && r.cts_ms != 10'h3ff) n.cts_ms = r.cts_ms + 10'h001;

      // Sequencer
      case (r.st)
         smh_pkg::SMH_IDLE: begin
            if (r.pend) begin
               n.tmr = r.delay[15:0];                            // [R18]
               n.st  = smh_pkg::SMH_PRE;
            end
         end
         smh_pkg::SMH_PRE: begin
            if (r.tmr == 16'h0000) begin
               n.cts_ms = 10'h000;
               n.tmr    = units_ms(lead_ms_u);                   // [R8]
               n.st     = smh_pkg::SMH_LEAD;
            end
         end
         smh_pkg::SMH_LEAD: begin
            if (r.tmr == 16'h0000) begin
               n.tmr = 16'(r.ctrl[smh_pkg::CTRL_CCW_LSB +: 16]);
               n.st  = (mode == smh_pkg::SMH_CARRIER && dcd) ? smh_pkg::SMH_WDCD
                                                             : smh_pkg::SMH_WCTS;
            end
         end
         smh_pkg::SMH_WDCD: begin
            if (!dcd) begin
               n.st = smh_pkg::SMH_WCTS;
            end else if (r.tmr == 16'h0000) begin
               n.status[smh_pkg::ST_ABORT_DCD] = 1'b1;           // [R7]
               n.pend = 1'b0;
               n.st   = smh_pkg::SMH_IDLE;
            end
         end
         smh_pkg::SMH_WCTS: begin
            if (go) begin
               n.st = smh_pkg::SMH_SEND;                         // [R9] [R10]
            end else if (r.cts_ms >= 10'(smh_pkg::CTS_WAIT_MS)) begin
               n.status[smh_pkg::ST_ABORT_CTS] = 1'b1;           // [R5] [R9] [R10]
               n.pend = 1'b0;
               n.st   = smh_pkg::SMH_IDLE;
            end
         end
         smh_pkg::SMH_SEND: begin
            // Start a character only while the line is clear
            if (r.txfull && r.tx_bit == 4'h0 && go) begin        // [R4]
               n.tx_sh  = r.ctrl[smh_pkg::CTRL_PAR_BIT]
                        ? {1'b1, even_par(r.txbyte), r.txbyte, 1'b0}      // [R13]
                        : {2'b11, r.txbyte, 1'b0};
               n.tx_bit = r.ctrl[smh_pkg::CTRL_PAR_BIT] ? 4'd11 : 4'd10;
               n.tx_div = r.baud;
               n.txfull = 1'b0;
               n.chk    = r.ctrl[smh_pkg::CTRL_CHK_BIT] ? crc_step(r.chk, r.txbyte)
                                                         : r.chk + {8'h00, r.txbyte}; // [R15]
               if (r.last) begin
                  n.st = smh_pkg::SMH_TRAIL;
               end
            end
         end
         smh_pkg::SMH_TRAIL: begin
            if (r.tx_bit != 4'h0) begin
               n.tmr = units_ms(trail_u);                        // [R11]
            end else if (r.tmr == 16'h0000) begin
               n.status[smh_pkg::ST_SENT] = 1'b1;
               n.pend = 1'b0;
               n.st   = smh_pkg::SMH_IDLE;
            end
         end
         default: n.st = smh_pkg::SMH_IDLE;
      endcase

      // Bit-serial transmitter
      if (r.tx_bit != 4'h0) begin
         if (r.tx_div == 16'h0000) begin
            n.tx_div = r.baud;
            n.txd    = r.tx_sh[0];
            n.tx_sh  = {1'b1, r.tx_sh[10:1]};
            n.tx_bit = r.tx_bit - 4'h1;
         end else begin
            n.tx_div = r.tx_div - 16'h0001;
         end
      end else begin
         n.txd = 1'b1;
      end

      // Receiver, gated by carrier in carrier-sense mode
      if (!r.rx_busy) begin
         if (!r.rxd_s[1] && (mode != smh_pkg::SMH_CARRIER || dcd)) begin   // [R6]
            n.rx_busy = 1'b1;
            n.rx_div  = {1'b0, r.baud[15:1]};
            n.rx_bit  = r.ctrl[smh_pkg::CTRL_PAR_BIT] ? 4'd11 : 4'd10;
         end
      end else if (r.rx_div == 16'h0000) begin
         n.rx_div = r.baud;
         n.rx_sh  = {r.rxd_s[1], r.rx_sh[9:1]};
         n.rx_bit = r.rx_bit - 4'h1;
         if (r.rx_bit == 4'h1) begin
            n.rx_busy = 1'b0;
            if (mode != smh_pkg::SMH_CARRIER || dcd) begin       // [R6]
               if (r.ctrl[smh_pkg::CTRL_PAR_BIT]) begin
                  n.rxbyte = r.rx_sh[8:1];
                  // Set after the read clear, so a status read in the same cycle cannot lose it
                  if (even_par(r.rx_sh[8:1]) != r.rx_sh[9]) begin
                     n.status[smh_pkg::ST_PERR] = 1'b1;            // [R13]
                  end
               end else begin
                  n.rxbyte = r.rx_sh[9:2];
               end
               n.status[smh_pkg::ST_RX] = 1'b1;
            end
         end
      end else begin
         n.rx_div = r.rx_div - 16'h0001;
      end

      // RTS per control-line mode
      case (mode)
         smh_pkg::SMH_NOHS: n.rts = 1'b0;                        // [R1]
         smh_pkg::SMH_FULL: n.rts = 1'b1;                        // [R2] [R17]
         default: n.rts = (n.st == smh_pkg::SMH_LEAD) || (n.st == smh_pkg::SMH_WDCD) ||
                          (n.st == smh_pkg::SMH_WCTS) || (n.st == smh_pkg::SMH_SEND) ||
                          (n.st == smh_pkg::SMH_TRAIL);          // [R3]
      endcase

      if (i_rst) begin
         n = '0;
         n.ctrl  = smh_pkg::CTRL_RST;
         n.delay = smh_pkg::DELAY_RST;
         n.baud  = smh_pkg::BAUD_RST;
         n.txd   = 1'b1;
         n.cts_s = 2'b00;
         n.rxd_s = 2'b11;
         n.rx_sh = 10'h3ff;
         n.st    = smh_pkg::SMH_IDLE;
      end
   end

   // State register
   always_ff @(posedge i_ref_clk) begin
      r <= n;
   end

   assign o_rdata = r.rdata;
   assign o_rts   = r.rts;
   assign o_txd   = r.txd;
   assign o_irq   = |(r.status & r.mask);
endmodule : smh_top

// ==== bench/smh_props.sv ====
// Port checker for the modem handshake sequencer
`timescale 1ns/1ns
module smh_props (
   input wire logic        i_ref_clk,
   input wire logic        i_rst,
   input wire logic [3:0]  i_addr,
   input wire logic [31:0] i_wdata,
   input wire logic        i_wr,
   input wire logic        i_rd,
   input wire logic [31:0] o_rdata,
   input wire logic        i_cts,
   input wire logic        i_dcd,
   input wire logic        i_rxd,
   input wire logic        o_rts,
   input wire logic        o_txd,
   input wire logic        o_irq
);
   logic [2:0] mode;
   logic       ctl_w;
   default clocking @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);
   assign ctl_w = i_wr && i_addr == smh_pkg::REG_CTRL;
   // Mode as last taken by a control write
   always_ff @(posedge i_ref_clk) begin
      if (i_rst) mode <= 3'h0;
      else if (ctl_w && i_wdata[2:0] <= 3'h4) mode <= i_wdata[2:0];
   end
   property p_rd_idle; !$past(i_rd) |-> o_rdata == 32'h0000_0000; endproperty
   a_rd_idle: assert property (p_rd_idle) else $error("read data off cycle");
   property p_unmap; $past(i_rd) && $past(i_addr) > 4'h7 |-> o_rdata == 32'h0000_0000; endproperty
   a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
   property p_nohs; (mode == smh_pkg::SMH_NOHS) [*3] |-> !o_rts; endproperty
   a_nohs: assert property (p_nohs) else $error("rts high without handshake");
   property p_full; (mode == smh_pkg::SMH_FULL) [*3] |-> o_rts; endproperty
   a_full: assert property (p_full) else $error("rts low in full mode");
   property p_half; (mode == smh_pkg::SMH_HALF) [*3] ##0 !o_rts |-> o_txd; endproperty
   a_half: assert property (p_half) else $error("data sent without rts");
   property p_cts;
      mode inside {smh_pkg::SMH_FULL, smh_pkg::SMH_HALF} && $fell(o_txd) |-> $past(i_cts, 3);
   endproperty
   a_cts: assert property (p_cts) else $error("data sent without cts");
   property p_rst; $fell(i_rst) |-> !o_rts && o_txd && !o_irq; endproperty
   a_rst: assert property (p_rst) else $error("outputs wrong after reset");
   property p_rb;
      ctl_w && i_wdata[2:0] <= 3'h4 && i_wdata[15:8] != 8'hff ##2 i_rd && i_addr == 4'h0
      |=> (o_rdata & 32'hffff_ff1f) == ($past(i_wdata, 3) & 32'hffff_ff1f);
   endproperty
   a_rb: assert property (p_rb) else $error("control readback wrong");
   property p_bad; ctl_w && i_wdata[15:8] == 8'hff ##2 i_rd && i_addr == 4'h2 |=> o_rdata[5];
   endproperty
   a_bad: assert property (p_bad) else $error("broadcast address accepted");
   property p_mask; i_wr && i_addr == 4'h3 && i_wdata[5:0] == 6'h00 |-> ##2 !o_irq; endproperty
   a_mask: assert property (p_mask) else $error("irq while all masked");
   c_send: cover property (o_rts && !o_txd);
   c_rx: cover property (mode == smh_pkg::SMH_CARRIER && i_dcd && !i_rxd);
   c_irq: cover property ($rose(o_irq));
endmodule : smh_props

// ==== bench/smh_modem_model.sv ====
// Behavioural serial modem facing the sequencer
`timescale 1ns/1ns
module smh_modem_model #(
   parameter int BIT_CLKS = 4
) (
   input  wire logic       i_clk,
   input  wire logic       i_rts,
   input  wire logic       i_txd,
   input  wire logic       i_slow,
   input  wire logic       i_par,
   output logic            o_cts,
   output logic            o_rxd,
   output logic [8:0]      o_got,
   output int              o_cnt
);
   logic [3:0] rts_dly;
   initial begin
      rts_dly = 4'h0;
      o_cts = 1'b0;
      o_rxd = 1'b1;
      o_got = 9'h000;
      o_cnt = 0;
   end
   // CTS answers RTS after a short or long key-up
   always @(posedge i_clk) begin
      rts_dly <= {rts_dly[2:0], i_rts};
      o_cts <= i_slow ? rts_dly[3] : rts_dly[0];
   end
   // Frame capture: start, data LSB first, optional parity, stop
   always begin
      @(negedge i_txd);
      repeat (BIT_CLKS / 2) @(posedge i_clk);
      for (int k = 0; k < 9; k++) begin
         if (k < 8 || i_par) begin
            repeat (BIT_CLKS) @(posedge i_clk);
            o_got[k] = i_txd;
         end
      end
      repeat (BIT_CLKS) @(posedge i_clk);
      o_cnt++;
   end
   // Sends one frame without parity on the receive line
   task automatic send_byte(input logic [7:0] b);
      for (int k = 0; k < 10; k++) begin
         o_rxd <= k == 0 ? 1'b0 : k == 9 ? 1'b1 : b[k - 1];
         repeat (BIT_CLKS) @(posedge i_clk);
      end
   endtask : send_byte
endmodule : smh_modem_model

// ==== bench/testbench.sv ====
// Self-checking bench for the modem handshake sequencer
`timescale 1ns/1ns
module testbench;
   logic        i_ref_clk = 1'b0;
   logic        i_rst = 1'b1;
   logic [3:0]  i_addr = 4'h0;
   logic [31:0] i_wdata = 32'h0000_0000;
   logic        i_wr = 1'b0;
   logic        i_rd = 1'b0;
   logic        i_dcd = 1'b0;
   logic        slow = 1'b0;
   logic        par = 1'b0;
   logic        i_cts, i_rxd, o_rts, o_txd, o_irq;
   logic [31:0] o_rdata, rv, rb;
   logic [8:0]  got;
   logic [15:0] rng = 16'h000b;
   int          cnt;
   int          err_total = 0;
   int          num_checks = 0;
   always #4 i_ref_clk = ~i_ref_clk;
   smh_top DUT (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr), .i_wdata(i_wdata),
      .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cts(i_cts), .i_dcd(i_dcd),
      .i_rxd(i_rxd), .o_rts(o_rts), .o_txd(o_txd), .o_irq(o_irq));
   smh_modem_model #(.BIT_CLKS(4)) mdl (.i_clk(i_ref_clk), .i_rts(o_rts), .i_txd(o_txd),
      .i_slow(slow), .i_par(par), .o_cts(i_cts), .o_rxd(i_rxd), .o_got(got), .o_cnt(cnt));
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction : lfsr
   // Expected capture: even parity over the byte when enabled
   function automatic logic [8:0] exp_got(input logic [7:0] b, input logic p);
      return {p & ^b, b};
   endfunction : exp_got
   task automatic tally_and_finish;
      $display("checks %0d mismatches %0d", num_checks, err_total);
      if (err_total == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask : tally_and_finish
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e) begin
         err_total++;
         $display("mismatch at %0t: got %h expected %h", $time, g, e);
      end
   endtask : chk
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge i_ref_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_ref_clk);
      i_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge i_ref_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      @(posedge i_ref_clk);
      i_rd <= 1'b0;
      #1 d = o_rdata;
   endtask : rd
   // Bounded wait on rts, irq or the captured frame count
   task automatic wt(input int sel, input int v, input int lim);
      for (int n = 0; n < lim; n++) begin
         @(posedge i_ref_clk);
         if ((sel == 0 && o_rts === v[0]) || (sel == 1 && o_irq === v[0])) return;
         if (sel == 2 && cnt == v) return;
      end
      err_total++;
      $display("mismatch at %0t: wait ran out", $time);
      tally_and_finish();
   endtask : wt
   // One-byte packet in the given mode, then status and rts
   task automatic send_pkt(input logic [2:0] m, input logic p);
      logic [7:0] b;
      int         c0;
      rng = lfsr(rng);
      b = rng[7:0];
      par = p;
      c0 = cnt;
      wr(smh_pkg::REG_CTRL, {16'h0000, 8'h05, 3'h0, 1'b0, p, m});
      wr(smh_pkg::REG_SEND, 32'h0000_0001);
      wr(smh_pkg::REG_TXDATA, {23'h00_0000, 1'b1, b});
      wt(2, c0 + 1, 5000);
      chk(p ? got : {1'b0, got[7:0]}, exp_got(b, p));
      wt(1, 1, 200);
      rd(smh_pkg::REG_STATUS, rv);
      chk(32'(rv[0]), 32'h1);
      rd(smh_pkg::REG_RXDATA, rv);
      chk(32'(rv[31:16]), {24'h00_0000, b});
      wt(0, int'(m == 3'h1), 200);
      $display("packet in mode %0d done", m);
   endtask : send_pkt
   initial begin
      repeat (12) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      rd(smh_pkg::REG_CTRL, rv);
      chk(rv, smh_pkg::CTRL_RST);
      rd(smh_pkg::REG_BAUD, rv);
      chk(rv, {16'h0000, smh_pkg::BAUD_RST});
      wr(4'h9, 32'hffff_ffff);
      rd(4'h9, rv);
      chk(rv, 32'h0000_0000);
      $display("reset values done");
      // Random settings in every mode, read back whole
      for (int k = 0; k < 6; k++) begin
         rng = lfsr(rng);
         rv = {rng, k == 5 ? 8'hfe : rng[15:8] % 8'hff, 3'h0, rng[1:0], 3'(k % 5)};
         wr(smh_pkg::REG_CTRL, rv);
         rd(smh_pkg::REG_CTRL, rb);
         chk(rb, rv);
      end
      // Broadcast address refused, irq raised and cleared by read
      wr(smh_pkg::REG_MASK, 32'h0000_0020);
      wr(smh_pkg::REG_CTRL, 32'h0000_ff00);
      wt(1, 1, 20);
      rd(smh_pkg::REG_STATUS, rv);
      chk(32'(rv[5]), 32'h1);
      rd(smh_pkg::REG_CTRL, rv);
      chk(32'(rv[15:8]), 32'h0000_00fe);
      wt(1, 0, 20);
      // Refusal seen by a status read right after the write
      wr(smh_pkg::REG_CTRL, 32'h0000_ff00);
      rd(smh_pkg::REG_STATUS, rv);
      chk(32'(rv[5]), 32'h1);
      wr(smh_pkg::REG_MASK, 32'h0000_0000);
      $display("address refusal done");
      // Packets: half duplex with slow CTS, no handshake, radio, full duplex
      wr(smh_pkg::REG_BAUD, 32'h0000_0003);
      wr(smh_pkg::REG_MASK, 32'h0000_0001);
      slow = 1'b1;
      send_pkt(3'h2, 1'b1);
      slow = 1'b0;
      send_pkt(3'h0, 1'b0);
      send_pkt(3'h3, 1'b0);
      send_pkt(3'h1, 1'b1);
      // Carrier sense: receive with DCD, refuse to send while it stays
      wr(smh_pkg::REG_CTRL, 32'h0000_0504);
      wr(smh_pkg::REG_MASK, 32'h0000_000c);
      i_dcd <= 1'b1;
      mdl.send_byte(8'h5a);
      wt(1, 1, 100);
      rd(smh_pkg::REG_RXDATA, rv);
      chk(32'(rv[7:0]), 32'h0000_005a);
      rd(smh_pkg::REG_STATUS, rv);
      wr(smh_pkg::REG_SEND, 32'h0000_0001);
      wt(1, 1, 5000);
      rd(smh_pkg::REG_STATUS, rv);
      chk(32'(rv[2]), 32'h1);
      wt(0, 0, 200);
      i_dcd <= 1'b0;
      mdl.send_byte(8'h3c);
      rd(smh_pkg::REG_STATUS, rv);
      chk(32'(rv[3]), 32'h0);
      $display("carrier sense done");
      tally_and_finish();
   end
endmodule : testbench
bind smh_top smh_props u_props (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_addr(i_addr),
   .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_cts(i_cts),
   .i_dcd(i_dcd), .i_rxd(i_rxd), .o_rts(o_rts), .o_txd(o_txd), .o_irq(o_irq));
